/* File: hdl/pps_pin_select.sv */
module pps_pin_select #(
  parameter int STROBE_CYCLES = pps_pkg::PPS_STROBE_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Boot function strap pin
  input wire logic i_boot_function_select_pin,
  // Control pins: a is ready, b..d are space selects
  input wire logic [pps_pkg::PPS_NUM_PINS-1:0] i_port_io_line,
  output logic [pps_pkg::PPS_NUM_PINS-1:0] o_port_io_line,
  output logic [pps_pkg::PPS_NUM_PINS-1:0] o_port_io_line_oe,
  output logic o_mem_ready_pull_en,
  // GPIO function side
  input wire logic i_gpio_dir_wr,
  input wire logic [pps_pkg::PPS_NUM_PINS-1:0] i_gpio_dir_data,
  input wire logic [pps_pkg::PPS_NUM_PINS-1:0] i_gpio_out,
  output logic [pps_pkg::PPS_NUM_PINS-1:0] o_gpio_in,
  output logic [pps_pkg::PPS_NUM_PINS-1:0] o_gpio_dir,
  // Memory interface side
  input wire logic [pps_pkg::PPS_NUM_SEL-1:0] i_mem_space_select_n,
  input wire logic i_ready_pullup_dis,
  input wire logic i_access_start,
  output logic o_mem_ready_in,
  output logic o_access_busy,
  output logic o_access_done,
  output logic [pps_pkg::PPS_WAIT_CNT_W-1:0] o_access_wait_count,
  // Function status
  output logic o_func_valid,
  output logic o_func_mem
);
  import pps_pkg::*;

  // ****************************************************
  // Pin input synchronisers
  // ****************************************************
  logic boot_meta;
  logic boot_sync;
  logic [PPS_NUM_PINS-1:0] pin_meta;
  logic [PPS_NUM_PINS-1:0] pin_sync;

  // Two flops on every pin before any logic reads it
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      boot_meta <= 1'b0;
      boot_sync <= 1'b0;
      pin_meta <= '1;
      pin_sync <= '1;
    end
    else
    begin
      boot_meta <= i_boot_function_select_pin;
      boot_sync <= boot_meta;
      pin_meta <= i_port_io_line;
      pin_sync <= pin_meta;
    end
  end

  // ****************************************************
  // Boot function latch
  // ****************************************************
  pps_boot_t boot_state;
  pps_boot_t next_boot_state;
  logic [1:0] settle_cnt;
  logic [1:0] next_settle_cnt;
  pps_func_t func;
  pps_func_t next_func;

  // Wait for the strap to pass the synchroniser, then latch it once
  always_comb
  begin
    next_boot_state = boot_state;
    next_settle_cnt = settle_cnt;
    next_func = func;
    unique case (boot_state)
      PPS_BOOT_SETTLE:
      begin
        next_settle_cnt = settle_cnt + 2'h1;
        if (next_settle_cnt == PPS_SETTLE_CYCLES)
          next_boot_state = PPS_BOOT_LATCH;
      end
      PPS_BOOT_LATCH:
      begin
        if (boot_sync)
          next_func = PPS_FUNC_MEM; // RULE2
        else
          next_func = PPS_FUNC_GPIO; // RULE1
        next_boot_state = PPS_BOOT_RUN; // RULE3
      end
      PPS_BOOT_RUN:
      begin
        next_boot_state = PPS_BOOT_RUN; // RULE3
      end
      default:
      begin
        next_boot_state = PPS_BOOT_SETTLE;
      end
    endcase
  end

  // Boot latch registers
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      boot_state <= PPS_BOOT_SETTLE;
      settle_cnt <= 2'h0;
      func <= PPS_FUNC_GPIO;
    end
    else
    begin
      boot_state <= next_boot_state;
      settle_cnt <= next_settle_cnt;
      func <= next_func;
    end
  end

  logic func_valid;
  logic mem_mode;

  assign func_valid = (boot_state == PPS_BOOT_RUN);
  assign mem_mode = func_valid && (func == PPS_FUNC_MEM);

  // ****************************************************
  // GPIO direction
  // ****************************************************
  logic [PPS_NUM_PINS-1:0] gpio_dir;
  logic [PPS_NUM_PINS-1:0] next_gpio_dir;

  // Direction writes only count once the function is known to be GPIO
  always_comb
  begin
    next_gpio_dir = gpio_dir;
    if (i_gpio_dir_wr && func_valid && !mem_mode)
      next_gpio_dir = i_gpio_dir_data;
  end

  // Directions come out of reset as inputs
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      gpio_dir <= PPS_GPIO_DIR_RST; // RULE4
    else
      gpio_dir <= next_gpio_dir;
  end

  // ****************************************************
  // Pin drivers
  // ****************************************************
  logic [PPS_NUM_PINS-1:0] pin_out;
  logic [PPS_NUM_PINS-1:0] pin_oe;
  logic [PPS_NUM_PINS-1:0] next_pin_out;
  logic [PPS_NUM_PINS-1:0] next_pin_oe;
  logic pull_en;
  logic next_pull_en;

  // Route each pin from GPIO or memory function
  always_comb
  begin
    next_pin_out = PPS_PIN_OUT_RST;
    next_pin_oe = '0; // RULE6
    next_pull_en = 1'b1;
    if (mem_mode)
    begin
      // Ready pin stays an input; selects drive idle-high or active
      next_pin_oe[PPS_IDX_READY] = 1'b0; // RULE5
      next_pin_oe[PPS_IDX_SEL0 +: PPS_NUM_SEL] = '1; // RULE6
      next_pin_out[PPS_IDX_SEL0 +: PPS_NUM_SEL] =
        i_mem_space_select_n; // RULE5
      next_pull_en = !i_ready_pullup_dis; // RULE8
    end
    else if (func_valid)
    begin
      next_pin_out = i_gpio_out;
      next_pin_oe = gpio_dir; // RULE1
      next_pull_en = 1'b0;
    end
  end

  // Pin driver registers, floating with selects high in reset
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_out <= PPS_PIN_OUT_RST;
      pin_oe <= '0; // RULE6
      pull_en <= 1'b1;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pull_en <= next_pull_en;
    end
  end

  // ****************************************************
  // Inputs to the two functions
  // ****************************************************
  logic ready_level;

  // Ready reads high unless the pin carries the ready function
  assign ready_level = mem_mode ? pin_sync[PPS_IDX_READY] : 1'b1; // RULE8

  // ****************************************************
  // Wait-state extension
  // ****************************************************
  pps_access_wait #(
    .STROBE_CYCLES(STROBE_CYCLES)
  ) u_wait (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_start(i_access_start && mem_mode),
    .i_ready(ready_level), // RULE7
    .o_busy(o_access_busy),
    .o_done(o_access_done),
    .o_wait_count(o_access_wait_count)
  );

  // ****************************************************
  // Outputs
  // ****************************************************
  assign o_port_io_line = pin_out;
  assign o_port_io_line_oe = pin_oe;
  assign o_mem_ready_pull_en = pull_en;
  assign o_gpio_in = (func_valid && !mem_mode) ? pin_sync : '0;
  assign o_gpio_dir = gpio_dir;
  assign o_mem_ready_in = ready_level;
  assign o_func_valid = func_valid;
  assign o_func_mem = mem_mode;

endmodule

/* File: hdl/pps_pkg.sv */
// Functional notes
// (RULE1) Boot-select low during reset gives all four control pins to GPIO.
// (RULE2) Boot-select high during reset gives all four pins to the memory bus.
// (RULE3) The function is latched as reset is released and never changes.
// (RULE4) A pin given to GPIO leaves reset with its direction set to input.
// (RULE5) Pin a is memory ready; pins b, c, d are space 0, 1, 2 selects.
// (RULE6) A select pin floats in reset, then drives high as an output.
// (RULE7) Ready low from the far device stretches the access one cycle a time.
// (RULE8) The ready pin has a pull-up that the bus control setting can drop.
// (RULE9) Ready high at the check point ends the access with no more waits.
package pps_pkg;

  // ****************************************************
  // Pin indices and widths
  // ****************************************************
  localparam int PPS_NUM_PINS = 4;
  localparam int PPS_NUM_SEL = 3;
  localparam int PPS_IDX_READY = 0;
  localparam int PPS_IDX_SEL0 = 1;
  localparam int PPS_WAIT_CNT_W = 8;

  // ****************************************************
  // Reset values and timing counts
  // ****************************************************
  localparam logic [3:0] PPS_GPIO_DIR_RST = 4'h0;
  localparam logic [3:0] PPS_PIN_OUT_RST = 4'hf;
  localparam logic [2:0] PPS_SEL_IDLE = 3'h7;
  localparam logic [1:0] PPS_SETTLE_CYCLES = 2'h2;
  localparam int PPS_STROBE_CYCLES = 1;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic {
    PPS_FUNC_GPIO,
    PPS_FUNC_MEM
  } pps_func_t;

  typedef enum logic [1:0] {
    PPS_BOOT_SETTLE,
    PPS_BOOT_LATCH,
    PPS_BOOT_RUN
  } pps_boot_t;

  typedef enum logic [1:0] {
    PPS_ACC_IDLE,
    PPS_ACC_STROBE,
    PPS_ACC_CHECK
  } pps_acc_t;

endpackage

/* File: hdl/pps_access_wait.sv */
module pps_access_wait #(
  parameter int STROBE_CYCLES = pps_pkg::PPS_STROBE_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Access request from the memory engine
  input wire logic i_start,
  // Synchronised ready level, high when unused
  input wire logic i_ready,
  // Access status
  output logic o_busy,
  output logic o_done,
  output logic [pps_pkg::PPS_WAIT_CNT_W-1:0] o_wait_count
);
  import pps_pkg::*;

  localparam int CNT_W = (STROBE_CYCLES > 1) ? $clog2(STROBE_CYCLES) : 1;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYCLES - 1);

  pps_acc_t state;
  pps_acc_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [PPS_WAIT_CNT_W-1:0] wait_count;
  logic [PPS_WAIT_CNT_W-1:0] next_wait_count;
  logic done;
  logic next_done;

  // ****************************************************
  // Access sequencer
  // ****************************************************
  // Next state of strobe counter, wait counter and done pulse
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_wait_count = wait_count;
    next_done = 1'b0;
    unique case (state)
      PPS_ACC_IDLE:
      begin
        if (i_start)
        begin
          next_state = PPS_ACC_STROBE;
          next_cnt = '0;
          next_wait_count = '0;
        end
      end
      PPS_ACC_STROBE:
      begin
        if (cnt == STROBE_LAST)
          next_state = PPS_ACC_CHECK;
        else
          next_cnt = cnt + CNT_W'(1);
      end
      PPS_ACC_CHECK:
      begin
        if (i_ready)
        begin
          next_state = PPS_ACC_IDLE; // RULE9
          next_done = 1'b1;
        end
        else if (wait_count != '1)
          next_wait_count = wait_count + PPS_WAIT_CNT_W'(1); // RULE7
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= PPS_ACC_IDLE;
      cnt <= '0;
      wait_count <= '0;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      wait_count <= next_wait_count;
      done <= next_done;
    end
  end

  assign o_busy = (state != PPS_ACC_IDLE);
  assign o_done = done;
  assign o_wait_count = wait_count;

endmodule

/* File: dv/pps_pin_select_asserts.sv */
// ****
// Pin select checks
// ****
module pps_pin_select_asserts #(
  parameter int STROBE_CYCLES = 1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Watched ports
  input wire logic [2:0] i_mem_space_select_n,
  input wire logic i_ready_pullup_dis,
  input wire logic i_access_start,
  input wire logic [3:0] o_port_io_line,
  input wire logic [3:0] o_port_io_line_oe,
  input wire logic o_mem_ready_pull_en,
  input wire logic [3:0] o_gpio_dir,
  input wire logic o_access_busy,
  input wire logic o_access_done,
  input wire logic o_func_valid,
  input wire logic o_func_mem
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAT = STROBE_CYCLES + 2;
  logic go;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  // Accepted access request
  assign go = i_access_start && !o_access_busy && o_func_valid && o_func_mem;
  a_pins_float: assert property (!o_func_valid |-> o_port_io_line_oe == 4'h0
    && o_gpio_dir == 4'h0) else $error("pins driven before latch");
  a_mem_pins: assert property (o_func_valid && o_func_mem |=>
    o_port_io_line_oe == 4'he
    && o_port_io_line[3:1] == $past(i_mem_space_select_n))
    else $error("memory pin map wrong");
  a_gpio_oe: assert property (o_func_valid && !o_func_mem && $stable(o_gpio_dir)
    |=> !$stable(o_gpio_dir) || o_port_io_line_oe == o_gpio_dir)
    else $error("gpio enable not direction");
  a_func_fixed: assert property (o_func_valid |=> o_func_valid
    && $stable(o_func_mem)) else $error("function changed");
  a_pull_sel: assert property (o_func_valid |=> o_mem_ready_pull_en ==
    ($past(o_func_mem) && !$past(i_ready_pullup_dis)))
    else $error("pull-up state wrong");
  a_no_early: assert property (go |=> !o_access_done [*2])
    else $error("access ended early");
  a_done_bound: assert property (go |-> ##[LAT:40] o_access_done)
    else $error("access never ended");
  a_busy_end: assert property ($fell(o_access_busy) |-> o_access_done)
    else $error("busy fell without done");
  cover property (go);
  cover property (o_func_valid && !o_func_mem && o_gpio_dir != 4'h0);
  cover property (o_access_done && o_func_mem);
endmodule

/* File: dv/pps_mem_model.sv */
// ****
// External memory on the control pins
// ****
module pps_mem_model (
  // Clock
  input wire logic i_core_clk,
  // Pin drivers of both sides
  input wire logic [3:0] i_dut_out,
  input wire logic [3:0] i_dut_oe,
  input wire logic i_pull_en,
  input wire logic [3:0] i_ext_val,
  input wire logic [3:0] i_ext_en,
  input wire logic [7:0] i_wait_len,
  // Resolved pin levels
  output logic [3:0] o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h0;
  logic tgl = 1'b0;
  logic sel_q = 1'b0;
  logic sel_low;
  assign sel_low = (&i_dut_oe[3:1]) && !(&i_dut_out[3:1]);
  // Not-ready count loads when a select falls
  always @(posedge i_core_clk)
  begin
    tgl <= ~tgl;
    sel_q <= sel_low;
    if (sel_low && !sel_q)
      cnt <= i_wait_len;
    else if (cnt != 8'h0)
      cnt <= cnt - 8'h1;
  end
  // Released lines toggle so stale levels never pass
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      o_line[i] = i_dut_oe[i] ? i_dut_out[i] : i_ext_en[i] ? i_ext_val[i] : tgl;
    if (cnt != 8'h0)
      o_line[0] = 1'b0;
    else if (!i_dut_oe[0] && !i_ext_en[0] && i_pull_en)
      o_line[0] = 1'b1;
  end
endmodule

/* File: dv/tb_parallel_port_pin_select.sv */
module tb_parallel_port_pin_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STROBE = 1;
  logic clk = 0, nrst = 0, boot = 0, dir_wr = 0, dis = 0, start = 0;
  logic [3:0] line, out, oe, gin, gdir;
  logic [3:0] dir_data = 0, gout = 0, ext_val = 0, ext_en = 0;
  logic [2:0] sel_n = 3'h7;
  logic [7:0] wlen = 0, wcnt;
  logic pull, rdy, busy, done, fvalid, fmem;
  int n_mismatch = 0, num_checks = 0, cycles = 0;
  // ****
  // Clock, design and far side
  // ****
  always #2.5 clk = ~clk;
  pps_pin_select #(.STROBE_CYCLES(STROBE)) dut (.i_core_clk(clk),
    .i_nrst(nrst), .i_boot_function_select_pin(boot), .i_port_io_line(line),
    .o_port_io_line(out), .o_port_io_line_oe(oe), .o_mem_ready_pull_en(pull),
    .i_gpio_dir_wr(dir_wr), .i_gpio_dir_data(dir_data), .i_gpio_out(gout),
    .o_gpio_in(gin), .o_gpio_dir(gdir), .i_mem_space_select_n(sel_n),
    .i_ready_pullup_dis(dis), .i_access_start(start), .o_mem_ready_in(rdy),
    .o_access_busy(busy), .o_access_done(done), .o_access_wait_count(wcnt),
    .o_func_valid(fvalid), .o_func_mem(fmem));
  pps_mem_model mem (.i_core_clk(clk), .i_dut_out(out), .i_dut_oe(oe),
    .i_pull_en(pull), .i_ext_val(ext_val), .i_ext_en(ext_en),
    .i_wait_len(wlen), .o_line(line));
  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      end_of_test;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic b);
    nrst = 0;
    boot = b;
    tick(20);
    check(oe, 4'h0);
    check(gdir, 4'h0);
    check(pull, 1'b1);
    nrst = 1;
    tick(5);
    check(fmem, b);
  endtask
  task automatic run_access(output int n);
    start = 1;
    tick(1);
    start = 0;
    n = 0;
    while (done !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic t_gpio;
    do_reset(0);
    check(oe, 4'h0);
    check(pull, 1'b0);
    check(rdy, 1'b1);
    boot = 1;
    start = 1;
    tick(1);
    start = 0;
    tick(3);
    check(busy, 1'b0);
    check(fmem, 1'b0);
    gout = 4'h3;
    dir_data = 4'h5;
    dir_wr = 1;
    tick(1);
    dir_wr = 0;
    ext_val = 4'ha;
    ext_en = 4'ha;
    tick(4);
    check(oe, 4'h5);
    check(out & 4'h5, 4'h1);
    check(gin, 4'hb);
    ext_en = 0;
  endtask
  task automatic t_mem;
    int n;
    do_reset(1);
    check(oe, 4'he);
    check(out[3:1], 3'h7);
    for (int i = 0; i < 3; i++)
    begin
      sel_n = ~(3'h1 << i);
      tick(2);
      check(out[3:1], sel_n);
    end
    sel_n = 3'h7;
    dir_data = 4'hf;
    dir_wr = 1;
    tick(1);
    dir_wr = 0;
    dis = 1;
    tick(2);
    check(gdir, 4'h0);
    check(pull, 1'b0);
    dis = 0;
    boot = 0;
    tick(4);
    check(pull, 1'b1);
    check(fmem, 1'b1);
    run_access(n);
    check(n, STROBE + 1);
    check(wcnt, 8'h0);
    wlen = 8'd10;
    sel_n = 3'h6;
    tick(6);
    check(rdy, 1'b0);
    run_access(n);
    check(wcnt, 8'd6);
    check(n, STROBE + 1 + 6);
    sel_n = 3'h7;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    t_gpio;
    t_mem;
    end_of_test;
  end
endmodule
bind pps_pin_select pps_pin_select_asserts #(.STROBE_CYCLES(STROBE_CYCLES))
  u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_mem_space_select_n(i_mem_space_select_n),
  .i_ready_pullup_dis(i_ready_pullup_dis), .i_access_start(i_access_start),
  .o_port_io_line(o_port_io_line), .o_port_io_line_oe(o_port_io_line_oe),
  .o_mem_ready_pull_en(o_mem_ready_pull_en), .o_gpio_dir(o_gpio_dir),
  .o_access_busy(o_access_busy), .o_access_done(o_access_done),
  .o_func_valid(o_func_valid), .o_func_mem(o_func_mem));
